//--- pin_sync.v
// Three-stage input synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rstn,
  // Pins in, clean levels out
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_lane
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      always @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          lvl_r <= 1'b0;
        end
        else
        begin
          s1_r <= pin_in[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // Only stages two and three are compared, never the first
          if (s2_r == s3_r)
            lvl_r <= s3_r;
        end
      end
      assign level_out[g] = lvl_r;
    end
  endgenerate

endmodule // pin_sync

`default_nettype wire

//--- preset_speed_sequencer.v
// Preset speed sequencer with APB register file
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

module preset_speed_sequencer #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rstn,
  // APB slave
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [7:0]   paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  // Digital input pins one to six
  input  wire [5:0]   din,
  // Preset frequencies, preset n in bits 16n+15:16n
  input  wire [127:0] preset_freq,
  // Other command and setpoint sources
  input  wire         ext_run,
  input  wire         ext_reverse,
  input  wire [15:0]  ext_setpoint,
  // Drive command
  output reg          drive_run,
  output reg          drive_reverse,
  output reg  [15:0]  drive_setpoint,
  // Sequencer state
  output reg          seq_active,
  output reg          seq_paused,
  output reg  [2:0]   seq_step,
  output reg          step_end,
  output reg          cycle_end
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_GAP  = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  reg  [7:0]  mode_r;
  reg  [7:0]  dir_prog_r;
  reg  [2:0]  start_sel_r;
  reg  [2:0]  pause_sel_r;
  reg  [15:0] run_time_r [0:7];
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [2:0]  step_r;
  reg  [2:0]  step_nxt;
  reg  [15:0] elapsed_r;
  reg  [15:0] elapsed_nxt;
  reg         step_end_nxt;
  reg         cycle_end_nxt;
  reg  [2:0]  first_idx;
  reg         first_ok;
  reg  [2:0]  next_idx;
  reg         next_ok;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg  [15:0] wr_time;
  wire [5:0]  din_lvl;
  wire        tick;
  wire        start_in;
  wire        pause_in;
  wire        mode_ok;
  wire        stepped;
  wire        looping;
  wire        apb_wr;
  integer     k;
  integer     j;

  // ----------------------------------------
  // Input pins and the one-second base
  // ----------------------------------------
  pin_sync #(.W (6)) u_sync (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .pin_in    (din),
    .level_out (din_lvl)
  );

  sec_tick #(
    .CYCLES    (TICK_CYCLES)
  ) u_tick (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .clear     ((state_nxt != state_r) || (step_nxt != step_r)),
    .tick      (tick)
  );

  // Assignment 0 or above six leaves the function unconnected
  assign start_in = (start_sel_r != 3'h0) && (start_sel_r <= `NUM_INPUTS) &&
                    din_lvl[start_sel_r - 3'h1];
  assign pause_in = (pause_sel_r != 3'h0) && (pause_sel_r <= `NUM_INPUTS) &&
                    din_lvl[pause_sel_r - 3'h1];

  // Codes above four decode as disabled
  assign mode_ok = (mode_r >= `MODE_ONCE) && (mode_r <= `MODE_STEP_CONT);
  assign stepped = (mode_r == `MODE_STEP_ONCE) || (mode_r == `MODE_STEP_CONT);
  assign looping = (mode_r == `MODE_CONT) || (mode_r == `MODE_STEP_CONT);

  // ----------------------------------------
  // Active preset search
  // ----------------------------------------
  always @*
  begin
    first_ok = 1'b0;
    first_idx = 3'h0;
    next_ok = 1'b0;
    next_idx = 3'h0;
    for (k = 7; k >= 0; k = k - 1)
    begin
      if (run_time_r[k] != 16'h0000)
      begin
        first_ok = 1'b1;
        first_idx = k[2:0];
        if (k[2:0] > step_r)
        begin
          next_ok = 1'b1;
          next_idx = k[2:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  always @*
  begin
    state_nxt = state_r;
    step_nxt = step_r;
    elapsed_nxt = elapsed_r;
    step_end_nxt = 1'b0;
    cycle_end_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (start_in && mode_ok && first_ok)
        begin
          state_nxt = ST_RUN;
          step_nxt = first_idx;
          elapsed_nxt = 16'h0000;
        end
      end
      ST_RUN:
      begin
        // Pause freezes both the step and its elapsed seconds
        if (tick && !pause_in)
        begin
          if (elapsed_r + 16'h0001 >= run_time_r[step_r])
          begin
            step_end_nxt = 1'b1;
            elapsed_nxt = 16'h0000;
            if (next_ok)
            begin
              step_nxt = next_idx;
              state_nxt = stepped ? ST_GAP : ST_RUN;
            end
            else
            begin
              cycle_end_nxt = 1'b1;
              step_nxt = first_idx;
              if (looping && first_ok)
                state_nxt = stepped ? ST_GAP : ST_RUN;
              else
                state_nxt = ST_DONE;
            end
          end
          else
            elapsed_nxt = elapsed_r + 16'h0001;
        end
      end
      ST_GAP:
      begin
        // Stepped modes drop to zero for one second between presets
        if (tick && !pause_in)
          state_nxt = ST_RUN;
      end
      ST_DONE: state_nxt = ST_DONE;
      default: state_nxt = ST_IDLE;
    endcase
    // Losing start or mode ends the sequence at once
    if (!start_in || !mode_ok)
    begin
      state_nxt = ST_IDLE;
      step_nxt = 3'h0;
      elapsed_nxt = 16'h0000;
      cycle_end_nxt = 1'b0;
      step_end_nxt = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      step_r <= 3'h0;
      elapsed_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      elapsed_r <= elapsed_nxt;
    end
  end

  // ----------------------------------------
  // Drive command outputs
  // ----------------------------------------
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drive_run <= 1'b0;
      drive_reverse <= 1'b0;
      drive_setpoint <= 16'h0000;
      seq_active <= 1'b0;
      seq_paused <= 1'b0;
      seq_step <= 3'h0;
      step_end <= 1'b0;
      cycle_end <= 1'b0;
    end
    else
    begin
      seq_step <= step_nxt;
      step_end <= step_end_nxt;
      cycle_end <= cycle_end_nxt;
      seq_active <= (state_nxt == ST_RUN) || (state_nxt == ST_GAP);
      seq_paused <= pause_in && (state_nxt != ST_IDLE) && (state_nxt != ST_DONE);
      if (mode_ok)
      begin
        // With the sequencer enabled only its start input runs the drive
        drive_run <= (state_nxt == ST_RUN);
        drive_reverse <= dir_prog_r[step_nxt];
        drive_setpoint <= (state_nxt == ST_RUN) ? preset_freq[step_nxt*16 +: 16] : 16'h0000;
      end
      else
      begin
        drive_run <= ext_run;
        drive_reverse <= ext_reverse;
        drive_setpoint <= ext_setpoint;
      end
    end
  end

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  // Answer comes one cycle after setup, so read data can be registered
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;

  always @*
  begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    wr_time = (pwdata[15:0] > `RUN_TIME_MAX) ? `RUN_TIME_MAX : pwdata[15:0];
    if ((paddr >= `OFS_RUN_TIME0) && (paddr <= `OFS_RUN_TIME7) && (paddr[1:0] == 2'b00))
      rd_data = {16'h0000, run_time_r[paddr[4:2] - 3'h4]};
    else
    begin
      case (paddr)
        `OFS_MODE:      rd_data = {24'h000000, mode_r};
        `OFS_DIR_PROG:  rd_data = {24'h000000, dir_prog_r};
        `OFS_START_SEL: rd_data = {29'h00000000, start_sel_r};
        `OFS_PAUSE_SEL: rd_data = {29'h00000000, pause_sel_r};
        `OFS_STATUS:    rd_data = {elapsed_r, 8'h00, pause_in, start_in, state_r, 1'b0, step_r};
        default:        rd_err = 1'b1;
      endcase
    end
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mode_r <= `RST_MODE;
      dir_prog_r <= `RST_DIR_PROG;
      start_sel_r <= `RST_SEL;
      pause_sel_r <= `RST_SEL;
      for (j = 0; j < 8; j = j + 1)
        run_time_r[j] <= `RST_RUN_TIME;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      if (psel && !penable && !pwrite)
        prdata <= rd_data;
      if (apb_wr)
      begin
        if ((paddr >= `OFS_RUN_TIME0) && (paddr <= `OFS_RUN_TIME7))
          run_time_r[paddr[4:2] - 3'h4] <= wr_time;
        else
        begin
          case (paddr)
            `OFS_MODE:      mode_r <= pwdata[7:0];
            `OFS_DIR_PROG:  dir_prog_r <= pwdata[7:0];
            `OFS_START_SEL: start_sel_r <= pwdata[2:0];
            `OFS_PAUSE_SEL: pause_sel_r <= pwdata[2:0];
            default:        mode_r <= mode_r;
          endcase
        end
      end
    end
  end

endmodule // preset_speed_sequencer

`default_nettype wire

//--- preset_speed_sequencer_test.sv
// Self-checking testbench of the preset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"
module preset_speed_sequencer_test;
  localparam int T = 8;
  logic         sys_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h00000000;
  logic [5:0]   din = 6'h00;
  logic [127:0] preset_freq = 128'h0;
  logic         ext_run = 1'b0;
  logic         ext_reverse = 1'b0;
  logic [15:0]  ext_setpoint = 16'h0000;
  wire  [31:0]  prdata;
  wire          pready, pslverr, drive_run, drive_reverse, seq_active, seq_paused, step_end, cycle_end;
  wire  [15:0]  drive_setpoint;
  wire  [2:0]   seq_step;
  int           errors = 0;
  int           samples_checked = 0;
  int           rt[8];
  int           ss, ps, k;
  logic [7:0]   dp;
  logic [31:0]  s = 32'h00014059;
  logic [31:0]  r, d;
  logic         e;

  preset_speed_sequencer #(.TICK_CYCLES(T)) preset_speed_sequencer_i (.sys_clk, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .din, .preset_freq, .ext_run, .ext_reverse,
    .ext_setpoint, .drive_run, .drive_reverse, .drive_setpoint, .seq_active, .seq_paused, .seq_step,
    .step_end, .cycle_end);

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tk();
    @(posedge sys_clk);
    #1;
  endtask

  // One APB transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only ready ends this wait; the watchdog catches a slave that never answers
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, d, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, d, e);
    chk(d, x);
    chk(e, 0);
  endtask

  // Bounded wait for a running step
  task automatic wt(input int i);
    int w;
    w = 0;
    while (!(seq_step === i[2:0] && drive_run === 1'b1) && w < 4 * T)
    begin
      tk();
      w++;
    end
    chk(seq_step, i);
  endtask

  // Whole program cycle in one mode, pause optional in the first step
  task automatic run(input logic [7:0] m, input logic pz);
    int i, c;
    wr(`OFS_MODE, {24'h0, m});
    din[ss] <= 1'b1;
    for (i = 0; i < 8; i++)
      if (rt[i] != 0)
      begin
        wt(i);
        chk(drive_setpoint, preset_freq[i*16+:16]);
        chk(drive_reverse, dp[i]);
        c = 0;
        if (pz && i == 0)
        begin
          repeat (T) tk();
          din[ps] <= 1'b1;
          repeat (2 * T) tk();
          chk(seq_paused, 1);
          chk(seq_step, i);
          din[ps] <= 1'b0;
        end
        // The previous step's end pulse may still stand here, so step past it first
        do
        begin
          tk();
          c++;
        end
        while (step_end !== 1'b1 && c < 4 * T);
        // Pause shifts the second boundary, so only clean steps are timed
        if (!pz || i != 0)
          chk(c >= rt[i] * T - 2 && c <= rt[i] * T + 2, 1);
        chk(cycle_end, i == 7);
      end
    if (m[0])
    begin
      repeat (3) tk();
      chk(drive_run, 0);
    end
    else
      wt(0);
    din[ss] <= 1'b0;
    repeat (6) tk();
    chk(drive_run, 0);
    chk(seq_active, 0);
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    for (k = 0; k <= 'h30; k += 4)
      rdc(8'(k), 0);
    apb(1'b0, 8'h42, 32'h0, d, e);
    chk({e, d[30:0]}, 32'h80000000);
    wr(`OFS_RUN_TIME0, 32'h0000FFFF);
    rdc(`OFS_RUN_TIME0, 32'h000003E8);
    preset_freq <= {rnd(), rnd(), rnd(), rnd()};
    r = rnd();
    dp = r[7:0];
    for (k = 0; k < 8; k++)
      rt[k] = rnd() % 3;
    rt[0] = 2;
    rt[1] = 0;
    rt[7] = 1;
    ss = rnd() % 6;
    ps = (ss + 1) % 6;
    wr(`OFS_DIR_PROG, {24'h0, dp});
    rdc(`OFS_DIR_PROG, {24'h0, dp});
    wr(`OFS_START_SEL, ss + 1);
    wr(`OFS_PAUSE_SEL, ps + 1);
    for (k = 0; k < 8; k++)
      wr(8'(`OFS_RUN_TIME0 + 4 * k), rt[k]);
    r = rnd();
    ext_run <= 1'b1;
    ext_reverse <= r[16];
    ext_setpoint <= r[15:0];
    din[ss] <= 1'b1;
    for (k = 0; k < 6; k += 5)
    begin
      wr(`OFS_MODE, k);
      repeat (8) tk();
      chk(drive_setpoint, r[15:0]);
      chk(drive_reverse, r[16]);
      chk(seq_active, 0);
    end
    rdc(`OFS_MODE, 5);
    din[ss] <= 1'b0;
    din[(ss + 2) % 6] <= 1'b1;
    // Let the old start level drain through the synchroniser before enabling
    repeat (6) tk();
    wr(`OFS_MODE, 1);
    repeat (10) tk();
    chk(seq_active, 0);
    chk(drive_run, 0);
    din[(ss + 2) % 6] <= 1'b0;
    run(1, 1);
    run(2, 0);
    run(3, 0);
    run(4, 0);
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end
endmodule // preset_speed_sequencer_test
`default_nettype wire

//--- sec_tick.v
// Restartable divider giving a one-cycle pulse per second of run time
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

module sec_tick #(
  parameter CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire rstn,
  // Restart the second, and the pulse
  input  wire clear,
  output reg  tick
);

  reg [31:0] cnt_r;

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b0;
    end
    else if (clear)
    begin
      // A step always starts on a fresh second
      cnt_r <= 32'h00000000;
      tick  <= 1'b0;
    end
    else if (cnt_r == CYCLES - 1)
    begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h00000001;
      tick  <= 1'b0;
    end
  end

endmodule // sec_tick

`default_nettype wire

//--- seq_map.vh
// Register map, field codes, reset values and timing counts of the preset sequencer
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MODE        8'h00
`define OFS_DIR_PROG    8'h04
`define OFS_START_SEL   8'h08
`define OFS_PAUSE_SEL   8'h0C
`define OFS_RUN_TIME0   8'h10
`define OFS_RUN_TIME7   8'h2C
`define OFS_STATUS      8'h30

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define MODE_OFF        8'h00
`define MODE_ONCE       8'h01
`define MODE_CONT       8'h02
`define MODE_STEP_ONCE  8'h03
`define MODE_STEP_CONT  8'h04

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RST_MODE        8'h00
`define RST_DIR_PROG    8'h00
`define RST_RUN_TIME    16'h0000
`define RST_SEL         3'h0
`define RUN_TIME_MAX    16'h03E8
`define NUM_INPUTS      3'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ          10000000
`define TICK_SEC        1
`define TICK_CYCLES     (`CLK_HZ * `TICK_SEC)

`endif

//--- seq_props.sv
// Port checker of the preset sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_props #(
  parameter TICK_CYCLES = 8
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // Bus handshake
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Sequencer outputs
  input wire logic       drive_run,
  input wire logic       drive_reverse,
  input wire logic       seq_active,
  input wire logic       seq_paused,
  input wire logic [2:0] seq_step,
  input wire logic       step_end,
  input wire logic       cycle_end
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Cycles since the last step end, saturating so a long pause cannot wrap it
  logic [31:0] age_r;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      age_r <= 32'hFFFFFFFF;
    else if (step_end)
      age_r <= 32'h00000000;
    else if (age_r != 32'hFFFFFFFF)
      age_r <= age_r + 32'h00000001;
  // ----------------
  // Checks
  // ----------------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_step_end_gap: assert property (step_end |=> !step_end [*4])
    else $error("steps too close");
  a_step_min_len: assert property (step_end |-> age_r >= TICK_CYCLES)
    else $error("step shorter than one second");
  a_cycle_end_last: assert property (cycle_end |-> step_end)
    else $error("cycle end off a step end");
  a_pause_holds: assert property (seq_paused ##1 seq_paused |-> $stable(seq_step) && !step_end)
    else $error("step moved in pause");
  a_step_rises: assert property (seq_active && $past(seq_active) && !cycle_end
    && seq_step != $past(seq_step) |-> seq_step > $past(seq_step))
    else $error("step order broken");
  a_dir_steady: assert property (seq_active && drive_run && $past(drive_run)
    && $stable(seq_step) |-> $stable(drive_reverse))
    else $error("direction moved in step");
  c_cycle_done: cover property (cycle_end);
  c_paused: cover property (seq_paused ##1 seq_paused);
  c_refused: cover property (pslverr);
endmodule // seq_props
bind preset_speed_sequencer seq_props #(.TICK_CYCLES(TICK_CYCLES)) seq_props_i (.sys_clk, .rstn,
  .psel, .penable, .pready, .pslverr, .drive_run, .drive_reverse, .seq_active, .seq_paused,
  .seq_step, .step_end, .cycle_end);
`default_nettype wire
